/* File: hdl/standby_halt_controller.v */
// Local design decisions: the register addresses and the address-and-strobe port.
`include "standby_halt_map.vh"
`default_nettype none

// How it works
// - Halt instruction enters mode by field: 11 CPU halt, 10 idle, 01 stop.
// - CPU-only halt stops execution; peripherals run per own idle-run bit.
// - Oscillator-only idle stops system clock; oscillator, calendar, melody run.
// - Full stop halts everything including the internal oscillator.
// - CPU-only halt freezes all I/O ports at their halt-time state.
// - Idle and stop drive or float pins per drive enable and select bits.
// - Enabled wake interrupt ends halt, gets serviced, then execution resumes.
// - Below-mask interrupt does not wake, except pin, key, calendar, alarm.
// - Non-maskable interrupt always wakes and is serviced, mask ignored.
// - Masked pin, key, calendar, alarm wake without service; flag stays set.
// - Wake sources: halt all; idle NMI/pin/alarm/key/calendar; stop NMI/pin/key.
// - Stop wake resumes only after oscillator warm-up has elapsed.
// - Wake during five-clock entry is held pending, not lost.
// - Later wake with one pending: higher priority served first, then other.
// - Reset ends any halt and reinitialises; interrupt wake keeps settings.
// - Requests sampled asynchronously; restart is synchronous to system clock.
// - After stop, resume in fast or slow clock per return select bit.
// - Warm-up field: 01 2^8, 10 2^14, 11 2^16 oscillator periods.
module standby_halt_controller #(
  parameter [16:0] WUP_MID = `HC_WUP_MID,
  parameter [16:0] WUP_LONG = `HC_WUP_LONG
) (
  input wire clk_sys,
  input wire arst_n,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire halt_exec,
  input wire [2:0] cpu_interrupt_mask,
  input wire nmi_irq,
  input wire [3:0] external_pin_irqs,
  input wire [4:0] alarm_irqs,
  input wire keypad_wake_irq,
  input wire calendar_irq,
  input wire watchdog_irq,
  input wire [3:0] timer_irqs,
  input wire [3:0] serial_irqs,
  input wire converter_irq,
  input wire serial_bus_irq,
  input wire [68:0] irq_levels,
  output wire cpu_run,
  output wire sys_clk_enable,
  output wire osc_enable,
  output wire [6:0] idle_run_enables,
  output wire port_hold,
  output wire pins_driven,
  output wire pins_float,
  output wire drive_select,
  output reg fast_osc_en,
  output reg slow_osc_en,
  output reg use_slow_clock,
  output reg resume_pulse,
  output reg resume_service,
  output reg [22:0] wake_sources,
  output reg [2:0] wake_level
);

  // ****************************************
  // States
  // ****************************************
  localparam [2:0] ST_RUN = 3'h0;
  localparam [2:0] ST_ENTER = 3'h1;
  localparam [2:0] ST_CPU_HALT = 3'h2;
  localparam [2:0] ST_OSC_IDLE = 3'h3;
  localparam [2:0] ST_STOP = 3'h4;
  localparam [2:0] ST_WARMUP = 3'h5;

  // ****************************************
  // Functions
  // ****************************************
  function [2:0] level_of;
    input [68:0] lv;
    input integer idx;
    begin
      level_of = lv[idx*3 +: 3];
    end
  endfunction

  function [22:0] mode_sources;
    input [1:0] mode;
    begin
      case (mode)
        `HC_MODE_CPU_HALT: mode_sources = `HC_ALL_SET;
        `HC_MODE_OSC_IDLE: mode_sources = `HC_OSC_IDLE_SET;
        `HC_MODE_STOP: mode_sources = `HC_STOP_SET;
        default: mode_sources = 23'h000000;
      endcase
    end
  endfunction

  function [2:0] max_level;
    input [22:0] sel;
    input [68:0] lv;
    integer k;
    begin
      max_level = 3'h0;
      for (k = 0; k < `HC_NSRC; k = k + 1)
      begin
        if (sel[k] && level_of(lv, k) > max_level)
          max_level = level_of(lv, k);
      end
      if (sel[0])
        max_level = 3'h7;
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] sys_two_r;
  reg [7:0] sys_zero_r;
  reg [6:0] idle_run_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [1:0] mode_r;
  reg [2:0] enter_cnt_r;
  reg [16:0] wup_cnt_r;
  reg [16:0] wup_target_r;
  reg [22:0] pending_r;
  reg [22:0] wake_hold_r;
  reg [22:0] enabled_vec;
  reg [22:0] wake_vec;
  integer i;

  wire [22:0] irq_raw;
  wire [22:0] irq_sync;
  wire [1:0] halt_mode_select;
  wire [1:0] warmup_time_select;
  wire [22:0] new_wake;
  wire halted_low;
  wire warmup_done;

  assign irq_raw = {serial_bus_irq, converter_irq, serial_irqs, timer_irqs, watchdog_irq,
                    calendar_irq, keypad_wake_irq, alarm_irqs, external_pin_irqs, nmi_irq};
  assign halt_mode_select = sys_two_r[`HC_HALT_MODE_LSB +: 2];
  assign warmup_time_select = sys_two_r[`HC_WARMUP_SEL_LSB +: 2];

  // Requests are caught without regard to the halted clock
  halt_irq_sync #(
    .W(`HC_NSRC)
  ) u_irq_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .async_in(irq_raw),
    .sync_out(irq_sync)
  );

  // ****************************************
  // Wake qualification
  // ****************************************
  always @*
  begin
    enabled_vec = 23'h000000;
    for (i = 0; i < `HC_NSRC; i = i + 1)
    begin
      enabled_vec[i] = (level_of(irq_levels, i) != 3'h0) &&
                       (level_of(irq_levels, i) >= cpu_interrupt_mask);
    end
    enabled_vec = enabled_vec | `HC_NMI_SET;
    wake_vec = irq_sync & mode_sources(mode_r) &
               (enabled_vec | `HC_MASKED_WAKE_SET);
  end

  assign new_wake = wake_vec & ~pending_r;

  // ****************************************
  // Sequencer
  // ****************************************
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:
        if (halt_exec)
        begin
          if (halt_mode_select == `HC_MODE_CPU_HALT)
            state_nxt = ST_CPU_HALT;
          else if (halt_mode_select != 2'h0)
            state_nxt = ST_ENTER;
        end
      ST_ENTER:
        if (enter_cnt_r == `HC_ENTER_CYCLES - 3'h1)
          state_nxt = (mode_r == `HC_MODE_STOP) ? ST_STOP : ST_OSC_IDLE;
      ST_CPU_HALT:
        if (|wake_vec)
          state_nxt = ST_RUN;
      ST_OSC_IDLE:
        if (|new_wake)
          state_nxt = ST_RUN;
      ST_STOP:
        if (|new_wake)
          state_nxt = ST_WARMUP;
      ST_WARMUP:
        if (warmup_done)
          state_nxt = ST_RUN;
      default:
        state_nxt = ST_RUN;
    endcase
  end

  assign warmup_done = (wup_cnt_r == wup_target_r - 17'h00001);

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= ST_RUN;
      mode_r <= 2'h0;
      enter_cnt_r <= 3'h0;
      wup_cnt_r <= 17'h00000;
      wup_target_r <= `HC_WUP_SHORT;
      pending_r <= 23'h000000;
      wake_hold_r <= 23'h000000;
      fast_osc_en <= 1'b1;
      slow_osc_en <= 1'b1;
      use_slow_clock <= 1'b0;
      resume_pulse <= 1'b0;
      resume_service <= 1'b0;
      wake_sources <= 23'h000000;
      wake_level <= 3'h0;
    end
    else
    begin
      state_r <= state_nxt;
      resume_pulse <= 1'b0;
      resume_service <= 1'b0;
      if (state_r == ST_RUN && halt_exec)
      begin
        mode_r <= halt_mode_select;
        enter_cnt_r <= 3'h0;
        pending_r <= 23'h000000;
      end
      if (state_r == ST_ENTER)
      begin
        enter_cnt_r <= enter_cnt_r + 3'h1;
        pending_r <= pending_r | wake_vec;
      end
      if ((state_r == ST_CPU_HALT && (|wake_vec)) ||
          (state_r == ST_OSC_IDLE && (|new_wake)))
      begin
        resume_pulse <= 1'b1;
        resume_service <= |((wake_vec | pending_r) & enabled_vec);
        wake_sources <= wake_vec | pending_r;
        wake_level <= max_level((wake_vec | pending_r) & enabled_vec, irq_levels);
        pending_r <= 23'h000000;
      end
      if (state_r == ST_STOP && (|new_wake))
      begin
        wake_hold_r <= wake_vec | pending_r;
        pending_r <= 23'h000000;
        wup_cnt_r <= 17'h00000;
        case (warmup_time_select)
          `HC_WUP_SHORT_SEL: wup_target_r <= `HC_WUP_SHORT;
          `HC_WUP_MID_SEL: wup_target_r <= WUP_MID;
          default: wup_target_r <= WUP_LONG;
        endcase
        fast_osc_en <= sys_zero_r[`HC_FASTEN_BIT];
        slow_osc_en <= sys_zero_r[`HC_SLOWEN_BIT];
      end
      if (state_r == ST_WARMUP)
      begin
        wup_cnt_r <= wup_cnt_r + 17'h00001;
        if (warmup_done)
        begin
          use_slow_clock <= sys_zero_r[`HC_RETSLOW_BIT];
          resume_pulse <= 1'b1;
          resume_service <= |(wake_hold_r & enabled_vec);
          wake_sources <= wake_hold_r;
          wake_level <= max_level(wake_hold_r & enabled_vec, irq_levels);
        end
      end
    end
  end

  // ****************************************
  // Block controls
  // ****************************************
  assign halted_low = (state_r == ST_OSC_IDLE) || (state_r == ST_STOP) ||
                      (state_r == ST_WARMUP);
  assign cpu_run = (state_r == ST_RUN);
  assign sys_clk_enable = !halted_low && (state_r != ST_ENTER);
  // Oscillator keeps running through entry and warm-up
  assign osc_enable = (state_r != ST_STOP);
  assign idle_run_enables = (state_r == ST_CPU_HALT) ? idle_run_r :
                            (halted_low ? 7'h00 : 7'h7F);
  assign port_hold = (state_r == ST_CPU_HALT);
  assign pins_driven = halted_low && sys_two_r[`HC_PIN_DRIVE_BIT];
  assign pins_float = halted_low && !sys_two_r[`HC_PIN_DRIVE_BIT];
  assign drive_select = sys_two_r[`HC_DRIVE_SEL_BIT];

  // ****************************************
  // Register port
  // ****************************************
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sys_two_r <= `HC_RST_SYS_TWO;
      sys_zero_r <= `HC_RST_SYS_ZERO;
      idle_run_r <= 7'h00;
      reg_rdata <= 8'h00;
    end
    else
    begin
      if (reg_wr)
      begin
        case (reg_addr)
          `HC_OFF_SYS_TWO: sys_two_r <= {2'h0, reg_wdata[5:0]};
          `HC_OFF_SYS_ZERO: sys_zero_r <= {5'h00, reg_wdata[2:0]};
          `HC_OFF_IDLE_RUN: idle_run_r <= reg_wdata[6:0];
          default: idle_run_r <= idle_run_r;
        endcase
      end
      reg_rdata <= 8'h00;
      if (reg_rd)
      begin
        case (reg_addr)
          `HC_OFF_SYS_TWO: reg_rdata <= sys_two_r;
          `HC_OFF_SYS_ZERO: reg_rdata <= sys_zero_r;
          `HC_OFF_IDLE_RUN: reg_rdata <= {1'b0, idle_run_r};
          `HC_OFF_STATUS: reg_rdata <= {2'h0, (state_r == ST_WARMUP), use_slow_clock,
                                        (|pending_r), state_r};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule // standby_halt_controller

`default_nettype wire

/* File: hdl/standby_halt_map.vh */
`ifndef STANDBY_HALT_MAP_VH
`define STANDBY_HALT_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define HC_OFF_SYS_TWO 4'h0
`define HC_OFF_SYS_ZERO 4'h1
`define HC_OFF_IDLE_RUN 4'h2
`define HC_OFF_STATUS 4'h3

// ****************************************
// Field positions
// ****************************************
`define HC_HALT_MODE_LSB 0
`define HC_PIN_DRIVE_BIT 2
`define HC_DRIVE_SEL_BIT 3
`define HC_WARMUP_SEL_LSB 4
`define HC_RETSLOW_BIT 0
`define HC_FASTEN_BIT 1
`define HC_SLOWEN_BIT 2
`define HC_STAT_PEND_BIT 3
`define HC_STAT_SLOW_BIT 4
`define HC_STAT_WUP_BIT 5

// ****************************************
// Reset values
// ****************************************
`define HC_RST_SYS_TWO 8'h23
`define HC_RST_SYS_ZERO 8'h06
`define HC_RST_IDLE_RUN 8'h00

// ****************************************
// Mode codes
// ****************************************
`define HC_MODE_CPU_HALT 2'h3
`define HC_MODE_OSC_IDLE 2'h2
`define HC_MODE_STOP 2'h1
`define HC_WUP_SHORT_SEL 2'h1
`define HC_WUP_MID_SEL 2'h2

// ****************************************
// Timing counts
// ****************************************
`define HC_ENTER_CYCLES 3'h5
`define HC_WUP_SHORT 17'h00100
`define HC_WUP_MID 17'h04000
`define HC_WUP_LONG 17'h10000

// ****************************************
// Source classes (bit 0 NMI, 1-4 pins, 5-9 alarm, 10 key, 11 calendar,
// 12 watchdog, 13-16 timers, 17-20 serial, 21 converter, 22 serial bus)
// ****************************************
`define HC_NSRC 23
`define HC_NMI_SET 23'h000001
`define HC_MASKED_WAKE_SET 23'h000FFE
`define HC_OSC_IDLE_SET 23'h000FFF
`define HC_STOP_SET 23'h00041F
`define HC_ALL_SET 23'h7FFFFF

`endif

/* File: hdl/halt_irq_sync.v */
`default_nettype none

// ****************************************
// Three-stage request synchroniser
// ****************************************
module halt_irq_sync #(
  parameter W = 23
) (
  input wire clk_sys,
  input wire arst_n,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  reg [W-1:0] out_r;

  // Accept a change only once stages two and three agree
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      out_r <= {W{1'b0}};
    end
    else
    begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= (s3_r & ~(s2_r ^ s3_r)) | (out_r & (s2_r ^ s3_r));
    end
  end

  assign sync_out = out_r;

endmodule // halt_irq_sync

`default_nettype wire

/* File: testbench/halt_checker_sva.sv */
`default_nettype none
// ****
// Standby port checker
// ****
module halt_checker (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic cpu_run,
  input wire logic sys_clk_enable,
  input wire logic osc_enable,
  input wire logic [6:0] idle_run_enables,
  input wire logic port_hold,
  input wire logic pins_driven,
  input wire logic pins_float,
  input wire logic resume_pulse,
  input wire logic resume_service,
  input wire logic [22:0] wake_sources
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  sequence s_warm;
    !cpu_run [*8];
  endsequence
  a_run_clocks: assert property (cpu_run |-> sys_clk_enable && osc_enable)
    else $error("run without clocks");
  a_stop_all: assert property (!osc_enable |->
    !sys_clk_enable && idle_run_enables == 7'h00)
    else $error("stop leaves logic running");
  a_hold_ports: assert property (port_hold |-> !cpu_run && sys_clk_enable)
    else $error("port hold outside cpu halt");
  a_pin_states: assert property ((pins_driven || pins_float) |->
    !sys_clk_enable && !(pins_driven && pins_float))
    else $error("pin state wrong");
  a_run_all_on: assert property (cpu_run |-> idle_run_enables == 7'h7F)
    else $error("peripheral gated while running");
  a_warm_wait: assert property ($rose(osc_enable) |-> s_warm)
    else $error("restart before warm-up");
  a_resume_sync: assert property (resume_pulse |-> cpu_run ##1 !resume_pulse)
    else $error("resume pulse wrong");
  a_nmi_service: assert property (resume_pulse && wake_sources[0] |-> resume_service)
    else $error("nmi wake not serviced");
  a_masked_kind: assert property (resume_pulse && !resume_service |->
    (wake_sources & 23'h7FF001) == 23'h0)
    else $error("unserviced wake from wrong source");
endmodule // halt_checker

bind standby_halt_controller halt_checker halt_checker_inst (.clk_sys(clk_sys), .arst_n(arst_n),
  .cpu_run(cpu_run), .sys_clk_enable(sys_clk_enable), .osc_enable(osc_enable),
  .idle_run_enables(idle_run_enables), .port_hold(port_hold), .pins_driven(pins_driven),
  .pins_float(pins_float), .resume_pulse(resume_pulse), .resume_service(resume_service),
  .wake_sources(wake_sources));
`default_nettype wire

/* File: testbench/irq_partner.sv */
`default_nettype none
// ****
// Interrupt source model
// ****
module irq_partner (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [22:0] fire,
  input wire logic resume_pulse,
  output logic [22:0] req
);
  timeunit 1ns;
  timeprecision 1ps;
  // Lines stay high until the wake is taken
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      req <= 23'h0;
    else if (resume_pulse)
      req <= fire;
    else
      req <= req | fire;
  end
endmodule // irq_partner
`default_nettype wire

/* File: testbench/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic halt_exec = 1'b0;
  logic [2:0] mask = 3'h0;
  logic [68:0] lv = {23{3'h3}};
  logic [22:0] fire = 23'h0;
  wire [22:0] req;
  wire [7:0] reg_rdata;
  wire [6:0] idle_run_enables;
  wire [22:0] wake_sources;
  wire [2:0] wake_level;
  wire cpu_run, osc_enable, port_hold, pins_driven, drive_select;
  wire use_slow_clock, resume_pulse, resume_service, fast_osc_en, slow_osc_en;
  int miscompares = 0;
  int samples_checked = 0;
  int n;
  int wup [3] = '{256, 16, 32};
  always #12.5 clk_sys = ~clk_sys;
  standby_halt_controller #(.WUP_MID(17'h00010), .WUP_LONG(17'h00020))
    standby_halt_controller_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_exec(halt_exec),
    .cpu_interrupt_mask(mask), .nmi_irq(req[0]), .external_pin_irqs(req[4:1]),
    .alarm_irqs(req[9:5]), .keypad_wake_irq(req[10]), .calendar_irq(req[11]),
    .watchdog_irq(req[12]), .timer_irqs(req[16:13]), .serial_irqs(req[20:17]),
    .converter_irq(req[21]), .serial_bus_irq(req[22]), .irq_levels(lv), .cpu_run(cpu_run),
    .sys_clk_enable(), .osc_enable(osc_enable), .idle_run_enables(idle_run_enables),
    .port_hold(port_hold), .pins_driven(pins_driven), .pins_float(), .drive_select(drive_select),
    .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en), .use_slow_clock(use_slow_clock),
    .resume_pulse(resume_pulse), .resume_service(resume_service),
    .wake_sources(wake_sources), .wake_level(wake_level));
  irq_partner irq_partner_inst (.clk_sys(clk_sys), .arst_n(arst_n), .fire(fire),
    .resume_pulse(resume_pulse), .req(req));
  // ****
  // Access and compare tasks
  // ****
  task chk(input logic [22:0] got, input logic [22:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task halt(input logic [22:0] f);
    // Let an earlier request drain from the synchroniser first
    repeat (6) @(posedge clk_sys);
    halt_exec <= 1'b1;
    fire <= f;
    @(posedge clk_sys);
    halt_exec <= 1'b0;
    fire <= 23'h0;
  endtask
  task poke(input logic [22:0] f);
    @(posedge clk_sys);
    fire <= f;
    @(posedge clk_sys);
    fire <= 23'h0;
  endtask
  task wt(input int mx);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (resume_pulse !== 1'b1 && n < mx);
  endtask
  task stop_test;
    $display("Checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial
  begin
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(4'h0, 8'h23);
    rd(4'h1, 8'h06);
    rd(4'h9, 8'h00);
    wr(4'h3, 8'hFF);
    rd(4'h3, 8'h00);
    $display("registers done");
    wr(4'h2, 8'h55);
    mask <= 3'h2;
    halt(23'h0);
    @(posedge clk_sys);
    #1;
    chk(cpu_run, 23'h0);
    chk(port_hold, 23'h1);
    chk(idle_run_enables, 23'h55);
    poke(23'h02000);
    wt(20);
    chk(resume_service, 23'h1);
    chk(wake_level, 23'h3);
    rd(4'h2, 8'h55);
    mask <= 3'h4;
    halt(23'h0);
    poke(23'h02000);
    wt(20);
    chk(n[22:0], 23'd20);
    poke(23'h00002);
    wt(20);
    chk(resume_service, 23'h0);
    chk(wake_sources, 23'h00002);
    $display("cpu halt done");
    mask <= 3'h0;
    wr(4'h0, 8'h22);
    halt(23'h0);
    repeat (8) @(posedge clk_sys);
    #1;
    chk(osc_enable, 23'h1);
    poke(23'h02000);
    wt(20);
    chk(n[22:0], 23'd20);
    poke(23'h00020);
    wt(20);
    chk(wake_sources, 23'h00020);
    halt(23'h00001);
    wt(12);
    chk(n[22:0], 23'd12);
    rd(4'h3, 8'h0B);
    poke(23'h00002);
    wt(20);
    chk(wake_sources, 23'h00003);
    chk(wake_level, 23'h7);
    $display("idle done");
    for (int i = 0; i < 3; i++)
    begin
      wr(4'h1, {5'h00, 1'(i != 1), 1'(i != 2), 1'(i == 2)});
      wr(4'h0, {2'b00, 2'(i + 1), 4'b1101});
      halt(23'h0);
      repeat (8) @(posedge clk_sys);
      #1;
      chk(osc_enable, 23'h0);
      chk(pins_driven, 23'h1);
      chk(drive_select, 23'h1);
      poke(23'h00400);
      wt(300);
      chk(23'(n >= wup[i] && n <= wup[i] + 10), 23'h1);
      chk(use_slow_clock, 23'(i == 2));
      chk(fast_osc_en, 23'(i != 2));
      chk(slow_osc_en, 23'(i != 1));
    end
    $display("stop done");
    wr(4'h0, 8'h1F);
    halt(23'h0);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(cpu_run, 23'h1);
    @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(4'h0, 8'h23);
    rd(4'h1, 8'h06);
    $display("reset done");
    stop_test;
  end
  initial
  begin
    #200000;
    miscompares++;
    stop_test;
  end
endmodule // tb
`default_nettype wire
